// ===== rmas_defs.svh
/*
 * constants of the register-map address select block: offsets, field positions,
 * reset values and map indices. assumes inclusion by bare name.
 */
`ifndef RMAS_DEFS_SVH
`define RMAS_DEFS_SVH

`define RMAS_SUB_SEL_OFS    8'h0E
`define RMAS_SUB_SEL_MSB    6
`define RMAS_SUB_SEL_LSB    5
`define RMAS_SUB_SEL_RESET  8'h00
`define RMAS_PP_ADDR_OFS    8'hFD
`define RMAS_SO_ADDR_OFS    8'hFE
`define RMAS_MAP_ADDR_RESET 8'h00
`define RMAS_MAIN_WR_ADDR   8'h40
`define RMAS_SEL_USER       2'h0
`define RMAS_SEL_INTR_VBI   2'h1
`define RMAS_SEL_USER2      2'h2
`define RMAS_MAP_USER       3'h0
`define RMAS_MAP_INTR_VBI   3'h1
`define RMAS_MAP_USER2      3'h2
`define RMAS_MAP_POSTPROC   3'h3
`define RMAS_MAP_SERIAL_OUT 3'h4
`define RMAS_MAP_COUNT      5
`define RMAS_SUB_LAST       8'hFF

`endif

// ===== rmas_host.sv
/*
 * two-wire bus host model: conditions and 9-bit byte slots.
 * assumes a pull-up on sda outside it; all moves follow a clk_i rising edge.
 */
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// bus host
// ****************************************
module rmas_host (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output var  logic scl_o,
	output var  logic sda_lo_o
);
	initial begin
		scl_o = 1'b1;
		sda_lo_o = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// sda moves mid low phase, so it never looks like a start or stop
	task automatic bit_io(input logic b, output logic r);
		scl_o <= 1'b0;
		tick(2);
		sda_lo_o <= ~b;
		tick(2);
		scl_o <= 1'b1;
		tick(4);
		r = sda_i;
	endtask

	// a = pull low during scl low, b = pull low after scl high: start is 0,1 and stop 1,0
	task automatic cond(input logic a, input logic b);
		scl_o <= 1'b0;
		tick(2);
		sda_lo_o <= a;
		tick(2);
		scl_o <= 1'b1;
		tick(4);
		sda_lo_o <= b;
		tick(4);
	endtask

	task automatic xfer(input logic [7:0] d, input logic l, output logic [7:0] q, output logic n);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(l, n);
	endtask
endmodule

`default_nettype wire

// ===== rmas_pkg.sv
/*
 * types of the register-map address select block.
 * assumes rmas_defs.svh for the numeric constants.
 */
`default_nettype none

package rmas_pkg;

	typedef enum logic [3:0] {
		RMAS_IDLE,
		RMAS_ADDR,
		RMAS_ADDR_ACK,
		RMAS_SUB,
		RMAS_SUB_ACK,
		RMAS_WDATA,
		RMAS_WDATA_ACK,
		RMAS_RDATA,
		RMAS_RDATA_ACK
	} rmas_state_t;

	typedef struct packed {
		logic       hit;
		logic [2:0] map;
	} rmas_map_sel_t;

endpackage

`default_nettype wire

// ===== rmas_sva.sv
/*
 * checker of the register-map address select block, watching its ports only.
 * assumes binding to rmas_top, ce_i held high and scl phases of 4 clocks or more.
 */
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// bus timing and register output checks
// ****************************************
module rmas_sva (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic       sda_o,
	input  wire logic       sda_oe_o,
	input  wire logic [1:0] sub_map_select_o,
	input  wire logic [6:0] postproc_map_addr_o,
	input  wire logic [6:0] serial_out_map_addr_o
);
	logic [2:0] low_cnt_q;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// saturates so a long low phase never wraps back into the legal window
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			low_cnt_q <= 3'h0;
		end else if (scl_i) begin
			low_cnt_q <= 3'h0;
		end else if (low_cnt_q != 3'h7) begin
			low_cnt_q <= low_cnt_q + 3'h1;
		end
	end

	sequence start_s;
		scl_i && $past(scl_i) && $fell(sda_i);
	endsequence

	sequence hold_s;
		sda_oe_o [*6];
	endsequence

	drive_low_a: assert property (sda_o == 1'b0)
		else $error("sda drive value not low");
	oe_edge_a: assert property ($changed(sda_oe_o) |-> low_cnt_q inside {[3'h1:3'h6]})
		else $error("sda enable moved outside scl low");
	oe_hold_a: assert property ($rose(sda_oe_o) |-> hold_s)
		else $error("sda enable released early");
	addr_quiet_a: assert property (start_s |-> !sda_oe_o [*8])
		else $error("sda driven during address phase");
	reset_vals_a: assert property ($rose(rst_n_i) |-> sub_map_select_o == 2'h0
		&& postproc_map_addr_o == 7'h00 && serial_out_map_addr_o == 7'h00)
		else $error("outputs not at reset value");
	pp_update_a: assert property ($changed(postproc_map_addr_o) |-> sda_oe_o || $past(sda_oe_o))
		else $error("postproc address changed without ack");
	so_update_a: assert property ($changed(serial_out_map_addr_o) |-> sda_oe_o || $past(sda_oe_o))
		else $error("serial out address changed without ack");
	sel_update_a: assert property ($changed(sub_map_select_o) |-> sda_oe_o || $past(sda_oe_o))
		else $error("select changed without ack");
endmodule

bind rmas_top rmas_sva rmas_sva_i (
	.clk_i                 (clk_i),
	.rst_n_i               (rst_n_i),
	.scl_i                 (scl_i),
	.sda_i                 (sda_i),
	.sda_o                 (sda_o),
	.sda_oe_o              (sda_oe_o),
	.sub_map_select_o      (sub_map_select_o),
	.postproc_map_addr_o   (postproc_map_addr_o),
	.serial_out_map_addr_o (serial_out_map_addr_o)
);

`default_nettype wire

// ===== rmas_top.sv
/*
 * two-wire serial slave with register-map address selection: a main map with three sub maps
 * and two secondary maps at programmable bus addresses.
 * assumes asynchronous scl, sda and address select pins; each scl phase spans 4+ clk_i cycles.
 */
// Function
// - the postprocessor map bus address comes from user sub map register 0xFD.
// - that register resets to 0x00 and the postprocessor map is unreachable until it is programmed.
// - bits 7 to 1 of 0xFD are the write address, the read address has bit 0 set.
// - with the serial output option the serial output map address comes from register 0xFE.
// - that register resets to 0x00 and the serial output map does not answer until programmed.
// - bits 7 to 1 of 0xFE are the write address, the read address has bit 0 set.
// - after reset main map accesses reach the user sub map.
// - the select field at 0x0E[6:5] routes main map accesses to the other sub maps.
// - select 00 is the user sub map, 01 the interrupt/vbi sub map, 10 the second user sub map.
// - the main map write address is 0x40 or 0x42, bit 1 taken from the address select pin.
`include "rmas_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module rmas_top #(
	parameter bit SERIAL_OUT_EN = 1'b1
) (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       ce_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output var  logic       sda_o,
	output var  logic       sda_oe_o,
	input  wire logic       address_select_pin_i,
	output var  logic [1:0] sub_map_select_o,
	output var  logic [6:0] postproc_map_addr_o,
	output var  logic [6:0] serial_out_map_addr_o
);

	// ****************************************
	// input synchronisers
	// ****************************************
	logic [2:0] scl_q;
	logic [2:0] sda_q;
	logic [1:0] pin_q;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_q <= 3'h7;
			sda_q <= 3'h7;
			pin_q <= 2'h0;
		end else if (ce_i) begin
			scl_q <= {scl_q[1:0], scl_i};
			sda_q <= {sda_q[1:0], sda_i};
			pin_q <= {pin_q[0], address_select_pin_i};
		end
	end
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	always_comb begin
		scl_rise = scl_q[1] & ~scl_q[2];
		scl_fall = ~scl_q[1] & scl_q[2];
		start_c  = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
		stop_c   = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
	end

	// ****************************************
	// address decode
	// ****************************************
	logic [7:0] sel_q;
	logic [7:0] pp_q;
	logic [7:0] so_q;
	logic [7:0] shift_q;
	function automatic rmas_pkg::rmas_map_sel_t decode(input logic [6:0] a, input logic pin,
			input logic [1:0] sel, input logic [7:0] pp, input logic [7:0] so);
		rmas_pkg::rmas_map_sel_t r;
		logic [7:0]              main_wr;
		r       = '0;
		main_wr = `RMAS_MAIN_WR_ADDR | {6'h00, pin, 1'b0};
		if (a == main_wr[7:1]) begin
			r.hit = (sel != 2'h3);
			case (sel)
				`RMAS_SEL_USER:     r.map = `RMAS_MAP_USER;
				`RMAS_SEL_INTR_VBI: r.map = `RMAS_MAP_INTR_VBI;
				`RMAS_SEL_USER2:    r.map = `RMAS_MAP_USER2;
				default:            r.map = `RMAS_MAP_USER;
			endcase
		end else if (pp[7:1] != 7'h00 && a == pp[7:1]) begin
			r.hit = 1'b1;
			r.map = `RMAS_MAP_POSTPROC;
		end else if (SERIAL_OUT_EN && so[7:1] != 7'h00 && a == so[7:1]) begin
			r.hit = 1'b1;
			r.map = `RMAS_MAP_SERIAL_OUT;
		end
		return r;
	endfunction
	rmas_pkg::rmas_map_sel_t addr_sel;
	always_comb begin
		addr_sel = decode(shift_q[7:1], pin_q[1], sel_q[`RMAS_SUB_SEL_MSB:`RMAS_SUB_SEL_LSB],
			pp_q, so_q);
	end

	// ****************************************
	// protocol engine
	// ****************************************
	rmas_pkg::rmas_state_t state_q;
	logic [7:0]            rsh_q;
	logic [3:0]            bit_q;
	logic [2:0]            map_q;
	logic [7:0]            sub_q;
	logic                  ovf_q;
	logic                  rw_q;
	logic [7:0]            rd_val;
	logic                  byte_end;
	logic                  do_write;
	logic                  main_map;
	always_comb begin
		byte_end = scl_fall && (bit_q == 4'h8);
		do_write = byte_end && (state_q == rmas_pkg::RMAS_WDATA) && !ovf_q;
		main_map = (map_q == `RMAS_MAP_USER) || (map_q == `RMAS_MAP_INTR_VBI)
			|| (map_q == `RMAS_MAP_USER2);
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q  <= rmas_pkg::RMAS_IDLE;
			shift_q  <= 8'h00;
			rsh_q    <= 8'h00;
			bit_q    <= 4'h0;
			map_q    <= `RMAS_MAP_USER;
			sub_q    <= 8'h00;
			ovf_q    <= 1'b0;
			rw_q     <= 1'b0;
			sda_oe_o <= 1'b0;
		end else if (ce_i) begin
			if (start_c) begin
				// a start anywhere, repeated or not, restarts address reception
				state_q  <= rmas_pkg::RMAS_ADDR;
				bit_q    <= 4'h0;
				sda_oe_o <= 1'b0;
			end else if (stop_c) begin
				state_q  <= rmas_pkg::RMAS_IDLE;
				sda_oe_o <= 1'b0;
			end else begin
				case (state_q)
					rmas_pkg::RMAS_ADDR, rmas_pkg::RMAS_SUB, rmas_pkg::RMAS_WDATA: begin
						if (scl_rise && bit_q != 4'h8) begin
							shift_q <= {shift_q[6:0], sda_q[1]};
							bit_q   <= bit_q + 4'h1;
						end
						if (byte_end) begin
							if (state_q == rmas_pkg::RMAS_ADDR) begin
								if (addr_sel.hit) begin
									map_q    <= addr_sel.map;
									rw_q     <= shift_q[0];
									sda_oe_o <= 1'b1;
									state_q  <= rmas_pkg::RMAS_ADDR_ACK;
								end else begin
									state_q <= rmas_pkg::RMAS_IDLE;
								end
							end else if (state_q == rmas_pkg::RMAS_SUB) begin
								sub_q    <= shift_q;
								ovf_q    <= 1'b0;
								sda_oe_o <= 1'b1;
								state_q  <= rmas_pkg::RMAS_SUB_ACK;
							end else if (ovf_q) begin
								// write past the last subaddress: no ack, back to idle
								state_q <= rmas_pkg::RMAS_IDLE;
							end else begin
								sda_oe_o <= 1'b1;
								state_q  <= rmas_pkg::RMAS_WDATA_ACK;
								if (sub_q == `RMAS_SUB_LAST) begin
									ovf_q <= 1'b1;
								end else begin
									sub_q <= sub_q + 8'h01;
								end
							end
						end
					end
					rmas_pkg::RMAS_ADDR_ACK: begin
						if (scl_fall) begin
							bit_q <= 4'h0;
							if (rw_q) begin
								state_q  <= rmas_pkg::RMAS_RDATA;
								rsh_q    <= {rd_val[6:0], 1'b0};
								sda_oe_o <= ~rd_val[7];
							end else begin
								state_q  <= rmas_pkg::RMAS_SUB;
								sda_oe_o <= 1'b0;
							end
						end
					end
					rmas_pkg::RMAS_SUB_ACK, rmas_pkg::RMAS_WDATA_ACK: begin
						if (scl_fall) begin
							bit_q    <= 4'h0;
							sda_oe_o <= 1'b0;
							state_q  <= rmas_pkg::RMAS_WDATA;
						end
					end
					rmas_pkg::RMAS_RDATA: begin
						if (scl_rise) begin
							bit_q <= bit_q + 4'h1;
						end
						if (scl_fall) begin
							if (bit_q == 4'h8) begin
								sda_oe_o <= 1'b0;
								state_q  <= rmas_pkg::RMAS_RDATA_ACK;
							end else begin
								sda_oe_o <= ~rsh_q[7];
								rsh_q    <= {rsh_q[6:0], 1'b0};
							end
						end
					end
					rmas_pkg::RMAS_RDATA_ACK: begin
						if (scl_rise) begin
							if (sda_q[1]) begin
								state_q <= rmas_pkg::RMAS_IDLE;
							end else if (sub_q != `RMAS_SUB_LAST) begin
								// past the last subaddress the last one keeps being read
								sub_q <= sub_q + 8'h01;
							end
						end
						if (scl_fall) begin
							bit_q    <= 4'h0;
							state_q  <= rmas_pkg::RMAS_RDATA;
							rsh_q    <= {rd_val[6:0], 1'b0};
							sda_oe_o <= ~rd_val[7];
						end
					end
					default: begin
						sda_oe_o <= 1'b0;
					end
				endcase
			end
		end
	end

	// ****************************************
	// register maps
	// ****************************************
	logic [7:0] map_mem [0:(`RMAS_MAP_COUNT*256)-1];
	logic [10:0] mem_idx;
	always_comb begin
		mem_idx = {map_q, sub_q};
		if (main_map && sub_q == `RMAS_SUB_SEL_OFS) begin
			rd_val = sel_q;
		end else if (map_q == `RMAS_MAP_USER && sub_q == `RMAS_PP_ADDR_OFS) begin
			rd_val = pp_q;
		end else if (map_q == `RMAS_MAP_USER && sub_q == `RMAS_SO_ADDR_OFS) begin
			rd_val = so_q;
		end else begin
			rd_val = map_mem[mem_idx];
		end
	end
	// the select register is visible from every main sub map, or no way back would exist
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sel_q <= `RMAS_SUB_SEL_RESET;
			pp_q  <= `RMAS_MAP_ADDR_RESET;
			so_q  <= `RMAS_MAP_ADDR_RESET;
		end else if (ce_i && do_write) begin
			if (main_map && sub_q == `RMAS_SUB_SEL_OFS) begin
				sel_q <= shift_q;
			end else if (map_q == `RMAS_MAP_USER && sub_q == `RMAS_PP_ADDR_OFS) begin
				pp_q <= shift_q;
			end else if (map_q == `RMAS_MAP_USER && sub_q == `RMAS_SO_ADDR_OFS) begin
				so_q <= shift_q;
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (ce_i && do_write) begin
			map_mem[mem_idx] <= shift_q;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sda_o                 <= 1'b0;
			sub_map_select_o      <= `RMAS_SEL_USER;
			postproc_map_addr_o   <= 7'h00;
			serial_out_map_addr_o <= 7'h00;
		end else if (ce_i) begin
			sda_o                 <= 1'b0;
			sub_map_select_o      <= sel_q[`RMAS_SUB_SEL_MSB:`RMAS_SUB_SEL_LSB];
			postproc_map_addr_o   <= pp_q[7:1];
			serial_out_map_addr_o <= so_q[7:1];
		end
	end

endmodule

`default_nettype wire

// ===== rmas_top_tb.sv
/*
 * self-checking bench of rmas_top with a bus host model.
 * assumes rmas_sva is bound to the design; the bus clock period is 320 ns.
 */
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// bench top
// ****************************************
module rmas_top_tb;
	logic       clk;
	logic       rst_n;
	logic       ce;
	logic       pin;
	logic       scl;
	logic       sda_lo;
	logic       oe;
	logic [1:0] sel;
	logic [6:0] pp;
	logic [6:0] so;
	logic [2:0] s;
	int         error_cnt;
	int         cmp_count;
	wire logic  sda = ~(sda_lo | oe);

	rmas_host rmas_host_i (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_lo_o(sda_lo));

	rmas_top rmas_top_i (
		.clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .scl_i(scl), .sda_i(sda), .sda_o(),
		.sda_oe_o(oe), .address_select_pin_i(pin), .sub_map_select_o(sel),
		.postproc_map_addr_o(pp), .serial_out_map_addr_o(so)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string n, input logic [7:0] v, input logic [7:0] e);
		cmp_count++;
		if (v !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", n, e, v);
		end
	endtask

	// k: whether the device is expected to answer at all
	task automatic wr(input logic [7:0] d, input logic [7:0] a, input logic [7:0] v, input logic k);
		logic [7:0] q;
		logic       r0;
		logic       r1;
		logic       r2;
		rmas_host_i.cond(1'b0, 1'b1);
		rmas_host_i.xfer(d, 1'b1, q, r0);
		rmas_host_i.xfer(a, 1'b1, q, r1);
		rmas_host_i.xfer(v, 1'b1, q, r2);
		rmas_host_i.cond(1'b1, 1'b0);
		chk("write acks", {5'h00, ~r0, ~r1, ~r2}, k ? 8'h07 : 8'h00);
	endtask

	task automatic rd(input logic [7:0] d, input logic [7:0] a, input logic [7:0] e, input logic k);
		logic [7:0] q;
		logic       r0;
		logic       r1;
		logic       r2;
		logic       r3;
		rmas_host_i.cond(1'b0, 1'b1);
		rmas_host_i.xfer(d, 1'b1, q, r0);
		rmas_host_i.xfer(a, 1'b1, q, r1);
		rmas_host_i.cond(1'b0, 1'b1);
		rmas_host_i.xfer(d | 8'h01, 1'b1, q, r2);
		rmas_host_i.xfer(8'hFF, 1'b1, q, r3);
		rmas_host_i.cond(1'b1, 1'b0);
		// the last slot is the host's own nack: the device must have let go of sda there
		chk("read acks", {4'h0, ~r0, ~r1, ~r2, ~r3}, k ? 8'h0E : 8'h00);
		if (k) chk("read data", q, e);
	endtask

	initial begin
		repeat (40000) @(posedge clk);
		error_cnt++;
		summarize();
	end

	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		pin = 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk("pp addr", {1'b0, pp}, 8'h00);
		chk("so addr", {1'b0, so}, 8'h00);
		chk("select", {6'h00, sel}, 8'h00);
		rd(8'h40, 8'h0E, 8'h00, 1'b1);
		wr(8'h84, 8'h10, 8'hA5, 1'b0);
		wr(8'h88, 8'h10, 8'hA5, 1'b0);
		$display("test reset done");
		wr(8'h40, 8'hFD, 8'h84, 1'b1);
		wr(8'h40, 8'hFE, 8'h88, 1'b1);
		chk("pp addr", {1'b0, pp}, 8'h84 >> 1);
		chk("so addr", {1'b0, so}, 8'h88 >> 1);
		rd(8'h40, 8'hFE, 8'h88, 1'b1);
		wr(8'h84, 8'h10, 8'hA5, 1'b1);
		wr(8'h88, 8'h10, 8'h3C, 1'b1);
		rd(8'h84, 8'h10, 8'hA5, 1'b1);
		rd(8'h88, 8'h10, 8'h3C, 1'b1);
		$display("test secondary maps done");
		for (s = 3'h0; s < 3'h3; s++) begin
			wr(8'h40, 8'h0E, {1'b0, s[1:0], 5'h00}, 1'b1);
			chk("select", {6'h00, sel}, {6'h00, s[1:0]});
			wr(8'h40, 8'h20, 8'h50 + {5'h00, s}, 1'b1);
		end
		for (s = 3'h0; s < 3'h3; s++) begin
			wr(8'h40, 8'h0E, {1'b0, s[1:0], 5'h00}, 1'b1);
			rd(8'h40, 8'h20, 8'h50 + {5'h00, s}, 1'b1);
		end
		wr(8'h40, 8'h0E, 8'h00, 1'b1);
		rd(8'h40, 8'hFD, 8'h84, 1'b1);
		$display("test sub maps done");
		@(posedge clk);
		pin <= 1'b1;
		repeat (4) @(posedge clk);
		wr(8'h40, 8'h21, 8'h00, 1'b0);
		rd(8'h42, 8'hFD, 8'h84, 1'b1);
		$display("test address pin done");
		ce <= 1'b0;
		wr(8'h42, 8'hFD, 8'h00, 1'b0);
		ce <= 1'b1;
		chk("pp addr", {1'b0, pp}, 8'h84 >> 1);
		wr(8'h42, 8'h0E, 8'h60, 1'b1);
		chk("select", {6'h00, sel}, 8'h03);
		wr(8'h42, 8'h0E, 8'h00, 1'b0);
		$display("test enable and select done");
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk("pp addr", {1'b0, pp}, 8'h00);
		chk("so addr", {1'b0, so}, 8'h00);
		chk("select", {6'h00, sel}, 8'h00);
		wr(8'h84, 8'h10, 8'hA5, 1'b0);
		rd(8'h42, 8'h0E, 8'h00, 1'b1);
		$display("test second reset done");
		summarize();
	end
endmodule

`default_nettype wire
